/* design/toi_tx_overhead.sv */
// Purpose: Transmit overhead insertion: spare bits, framing, AIS.
// Assumes: Line clocks and line-side inputs are asynchronous pins.
// Notes: The output bit changes one system clock after a sampled edge.
`timescale 1ns/100ps
module toi_tx_overhead (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic tx_clock_input,
  input wire logic e1_alternate_clock_input,
  input wire logic t1_alternate_clock_input,
  input wire logic tx_data_in,
  input wire logic rx_loss_of_signal_flag,
  output logic line_data_out,
  output logic line_clock_out,
  output logic tx_loss_of_clock_flag,
  output logic line_loopback_enable,
  output logic irq
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] line_test_path_config_reg;
  logic [7:0] tx_line_interface_config_reg;
  logic [7:0] tx_frame_format_config_reg;
  logic [7:0] tx_manual_spare_bit_config_reg;
  logic [7:0] tx_alarm_signal_config_reg;
  logic [7:0] spare_buf_reg [toi_pkg::SPARE_BUFS];
  logic [7:0] spare_shadow_reg [toi_pkg::SPARE_BUFS];
  logic [toi_pkg::EVT_COUNT-1:0] irq_status_reg;
  logic [toi_pkg::EVT_COUNT-1:0] irq_status_next;
  logic [toi_pkg::EVT_COUNT-1:0] irq_enable_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [7:0] bit_cnt_reg;
  logic [4:0] frm_cnt_reg;
  logic line_data_reg;
  logic line_data_next;
  logic line_clock_reg;
  logic clk_lost_last_reg;
  toi_pkg::toi_ais_t ais_state_reg;
  toi_pkg::toi_ais_t ais_state_next;

  // ----------------------------------------------------------------
  // Decoded controls
  // ----------------------------------------------------------------
  logic fbit_ins;
  logic mf_ins;
  logic [2:0] fmt;
  logic is_e1;
  logic alt_sel;
  logic manual_ais;
  logic on_signal_loss_a;
  logic tx_rise;
  logic alt_rise;
  logic last_bit;
  logic last_frm;
  logic mf_boundary;
  logic [7:0] bit_last;
  logic [4:0] frm_last;

  toi_edge_if tx_clk_e ();
  toi_edge_if e1_alt_e ();
  toi_edge_if t1_alt_e ();
  toi_edge_if data_e ();
  toi_edge_if sig_lost_e ();

  toi_edge_sync u_tx_clk (.clk(clk), .rst(rst), .async_in(tx_clock_input),
    .edge_o(tx_clk_e));
  toi_edge_sync u_e1_alt (.clk(clk), .rst(rst), .async_in(e1_alternate_clock_input),
    .edge_o(e1_alt_e));
  toi_edge_sync u_t1_alt (.clk(clk), .rst(rst), .async_in(t1_alternate_clock_input),
    .edge_o(t1_alt_e));
  toi_edge_sync u_data (.clk(clk), .rst(rst), .async_in(tx_data_in), .edge_o(data_e));
  toi_edge_sync u_sig_lost (.clk(clk), .rst(rst), .async_in(rx_loss_of_signal_flag),
    .edge_o(sig_lost_e));

  assign fbit_ins = tx_frame_format_config_reg[toi_pkg::FLD_FBIT_INS];
  assign mf_ins = tx_frame_format_config_reg[toi_pkg::FLD_MF_INS];
  assign fmt = tx_frame_format_config_reg[toi_pkg::FLD_FMT_LO +: 3];
  assign is_e1 = (fmt == toi_pkg::FMT_E1);
  assign alt_sel = tx_line_interface_config_reg[toi_pkg::FLD_ALT_CLK_AIS];
  assign manual_ais = tx_alarm_signal_config_reg[toi_pkg::FLD_MANUAL_AIS];
  assign on_signal_loss_a = tx_alarm_signal_config_reg[toi_pkg::FLD_ON_SIGNAL_LOSS];
  assign line_loopback_enable = line_test_path_config_reg[toi_pkg::FLD_LINE_LOOPBACK];
  assign tx_rise = tx_clk_e.rise;
  // The alternate clock must match the mode; the wrong one is ignored.
  assign alt_rise = is_e1 ? e1_alt_e.rise : t1_alt_e.rise;

  // ----------------------------------------------------------------
  // Loss of transmit clock
  // ----------------------------------------------------------------
  toi_clk_loss #(.LIMIT(toi_pkg::LOSS_EDGES)) u_clk_loss (.clk(clk), .rst(rst),
    .enable(alt_sel), .alt_rise(alt_rise), .tx_rise(tx_rise),
    .lost(tx_loss_of_clock_flag));

  // ----------------------------------------------------------------
  // Frame position
  // ----------------------------------------------------------------
  function automatic logic [4:0] frames_last(input logic [2:0] f);
    if (f == toi_pkg::FMT_E1) begin
      return toi_pkg::E1_LAST_FRM;
    end else if (f == toi_pkg::FMT_ESF) begin
      return toi_pkg::ESF_LAST_FRM;
    end
    return toi_pkg::SF_LAST_FRM;
  endfunction : frames_last

  assign bit_last = is_e1 ? toi_pkg::E1_LAST_BIT : toi_pkg::T1_LAST_BIT;
  assign frm_last = frames_last(fmt);
  assign last_bit = (bit_cnt_reg >= bit_last);
  assign last_frm = (frm_cnt_reg >= frm_last);
  // Spare bits ride the same counter as the CRC multiframe, so they never drift.
  assign mf_boundary = tx_rise && last_bit && last_frm;

  always_ff @(posedge clk) begin
    if (rst) begin
      bit_cnt_reg <= 8'h00;
    end else if (tx_rise) begin
      bit_cnt_reg <= last_bit ? 8'h00 : bit_cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      frm_cnt_reg <= 5'h00;
    end else if (tx_rise && last_bit) begin
      frm_cnt_reg <= last_frm ? 5'h00 : frm_cnt_reg + 5'h01;
    end
  end

  // ----------------------------------------------------------------
  // Spare-bit sampling
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    for (int i = 0; i < toi_pkg::SPARE_BUFS; i++) begin
      if (rst) begin
        spare_shadow_reg[i] <= toi_pkg::RST_CONFIG;
      end else if (mf_boundary && is_e1) begin
        spare_shadow_reg[i] <= spare_buf_reg[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Overhead insertion
  // ----------------------------------------------------------------
  function automatic logic pat6(input logic [5:0] w, input logic [4:0] idx);
    return w[3'(5 - int'(idx))];
  endfunction : pat6

  always_comb begin
    logic [2:0] ts0_bit;
    logic [4:0] f;
    logic odd_frm;
    ts0_bit = bit_cnt_reg[2:0];
    f = frm_cnt_reg;
    odd_frm = f[0];
    line_data_next = data_e.lvl;
    if (is_e1) begin
      if (bit_cnt_reg < 8'h08) begin
        if (!odd_frm && ts0_bit != 3'h0 && fbit_ins) begin
          line_data_next = toi_pkg::FAS_WORD[3'(7 - int'(ts0_bit))];
        end else if (odd_frm && ts0_bit == 3'h1 && fbit_ins) begin
          line_data_next = 1'b1;
        end else if (odd_frm && ts0_bit == 3'h0 && mf_ins && f < 5'h0C) begin
          line_data_next = pat6(toi_pkg::MFAS_WORD, 5'(f >> 1));
        end else if (odd_frm && ts0_bit >= 3'h3) begin
          // Disabled buffers pass the normal data through untouched.
          if (tx_manual_spare_bit_config_reg[ts0_bit - 3'h3]) begin
            line_data_next = spare_shadow_reg[ts0_bit - 3'h3][f[3:1]];
          end
        end
      end
    end else if (bit_cnt_reg == 8'h00) begin
      if (fmt == toi_pkg::FMT_ESF) begin
        if (fbit_ins && f[1:0] == 2'h3) begin
          line_data_next = pat6(toi_pkg::FPS_WORD, 5'(f >> 2));
        end
      end else if (!odd_frm) begin
        if (fbit_ins) begin
          line_data_next = pat6(toi_pkg::FT_WORD, 5'(f >> 1));
        end
      end else if (fmt == toi_pkg::FMT_SF && mf_ins) begin
        line_data_next = pat6(toi_pkg::FS_WORD, 5'(f >> 1));
      end
    end
  end

  // ----------------------------------------------------------------
  // AIS source selection
  // ----------------------------------------------------------------
  always_comb begin
    ais_state_next = toi_pkg::TOI_SEND_DATA;
    if (alt_sel && (manual_ais || tx_loss_of_clock_flag)) begin
      ais_state_next = toi_pkg::TOI_AIS_ALT;
    end else if (manual_ais || (on_signal_loss_a && sig_lost_e.lvl)) begin
      // With loopback on, this is the keep-alive toward the line.
      ais_state_next = toi_pkg::TOI_AIS_LINE;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ais_state_reg <= toi_pkg::TOI_SEND_DATA;
    end else begin
      ais_state_reg <= ais_state_next;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      line_data_reg <= 1'b1;
    end else begin
      unique case (ais_state_reg)
        toi_pkg::TOI_SEND_DATA: begin
          if (tx_rise) begin
            line_data_reg <= line_data_next;
          end
        end
        toi_pkg::TOI_AIS_LINE, toi_pkg::TOI_AIS_ALT: line_data_reg <= 1'b1;
        default: line_data_reg <= 1'b1;
      endcase
    end
  end

  // The outgoing clock is rebuilt from sampled levels, so it lags by three cycles.
  always_ff @(posedge clk) begin
    if (rst) begin
      line_clock_reg <= 1'b0;
    end else if (ais_state_reg == toi_pkg::TOI_AIS_ALT) begin
      line_clock_reg <= is_e1 ? e1_alt_e.lvl : t1_alt_e.lvl;
    end else begin
      line_clock_reg <= tx_clk_e.lvl;
    end
  end

  assign line_data_out = line_data_reg;
  assign line_clock_out = line_clock_reg;

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      clk_lost_last_reg <= 1'b0;
    end else begin
      clk_lost_last_reg <= tx_loss_of_clock_flag;
    end
  end

  // A new event in the clearing cycle survives the clear.
  always_comb begin
    irq_status_next = irq_status_reg;
    if (wr && addr == toi_pkg::OFS_IRQ_CLEAR) begin
      irq_status_next = irq_status_reg & ~wdata[toi_pkg::EVT_COUNT-1:0];
    end
    if (mf_boundary) begin
      irq_status_next[toi_pkg::EVT_MULTIFRAME] = 1'b1;
    end
    if (tx_loss_of_clock_flag && !clk_lost_last_reg) begin
      irq_status_next[toi_pkg::EVT_CLK_LOST] = 1'b1;
    end
    if (!tx_loss_of_clock_flag && clk_lost_last_reg) begin
      irq_status_next[toi_pkg::EVT_CLK_BACK] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_status_reg <= '0;
    end else begin
      irq_status_reg <= irq_status_next;
    end
  end

  assign irq = |(irq_status_reg & irq_enable_reg);

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      line_test_path_config_reg <= toi_pkg::RST_CONFIG;
      tx_line_interface_config_reg <= toi_pkg::RST_CONFIG;
      tx_frame_format_config_reg <= toi_pkg::RST_CONFIG;
      tx_manual_spare_bit_config_reg <= toi_pkg::RST_CONFIG;
      tx_alarm_signal_config_reg <= toi_pkg::RST_CONFIG;
      irq_enable_reg <= '0;
    end else if (wr) begin
      unique case (addr)
        toi_pkg::OFS_LINE_TEST_PATH: line_test_path_config_reg <= wdata;
        toi_pkg::OFS_TX_LINE_IF: tx_line_interface_config_reg <= wdata;
        toi_pkg::OFS_TX_FRAME_FMT: tx_frame_format_config_reg <= wdata;
        toi_pkg::OFS_TX_MAN_SPARE: tx_manual_spare_bit_config_reg <= wdata;
        toi_pkg::OFS_TX_ALARM: tx_alarm_signal_config_reg <= wdata;
        toi_pkg::OFS_IRQ_ENABLE: irq_enable_reg <= wdata[toi_pkg::EVT_COUNT-1:0];
        default: begin end
      endcase
    end
  end

  // Buffers are plain storage; only the multiframe sample makes them visible.
  always_ff @(posedge clk) begin
    for (int i = 0; i < toi_pkg::SPARE_BUFS; i++) begin
      if (rst) begin
        spare_buf_reg[i] <= toi_pkg::RST_CONFIG;
      end else if (wr && addr == toi_pkg::OFS_SPARE_FIRST + 8'(i)) begin
        spare_buf_reg[i] <= wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  always_comb begin
    rdata_next = 8'h00;
    if (addr >= toi_pkg::OFS_SPARE_FIRST && addr <= toi_pkg::OFS_SPARE_LAST) begin
      rdata_next = spare_buf_reg[3'(addr - toi_pkg::OFS_SPARE_FIRST)];
    end else begin
      unique case (addr)
        toi_pkg::OFS_LINE_TEST_PATH: rdata_next = line_test_path_config_reg;
        toi_pkg::OFS_TX_LINE_IF: rdata_next = tx_line_interface_config_reg;
        toi_pkg::OFS_TX_FRAME_FMT: rdata_next = tx_frame_format_config_reg;
        toi_pkg::OFS_TX_MAN_SPARE: rdata_next = tx_manual_spare_bit_config_reg;
        toi_pkg::OFS_TX_ALARM: rdata_next = tx_alarm_signal_config_reg;
        toi_pkg::OFS_IRQ_STATUS: rdata_next = 8'(irq_status_reg);
        toi_pkg::OFS_IRQ_ENABLE: rdata_next = 8'(irq_enable_reg);
        toi_pkg::OFS_LIVE_STATUS: rdata_next = {4'h0, ais_state_reg != toi_pkg::TOI_SEND_DATA,
                                                sig_lost_e.lvl, tx_loss_of_clock_flag, 1'b0};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    rdata_reg <= (rd && !rst) ? rdata_next : 8'h00;
  end

  assign rdata = rdata_reg;
endmodule : toi_tx_overhead

/* design/toi_pkg.sv */
// Purpose: Shared constants for the transmit overhead insertion block.
// Assumes: One framer, 8-bit register port, 25 MHz system clock.
// Notes: Offsets are byte addresses on the plain register port.
package toi_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_LINE_TEST_PATH = 8'h14;
  localparam logic [7:0] OFS_TX_LINE_IF = 8'h68;
  localparam logic [7:0] OFS_TX_FRAME_FMT = 8'h72;
  localparam logic [7:0] OFS_TX_MAN_SPARE = 8'h74;
  localparam logic [7:0] OFS_TX_ALARM = 8'h75;
  localparam logic [7:0] OFS_SPARE_FIRST = 8'h7B;
  localparam logic [7:0] OFS_SPARE_LAST = 8'h7F;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h90;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h91;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h92;
  localparam logic [7:0] OFS_LIVE_STATUS = 8'h93;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FLD_LINE_LOOPBACK = 0;
  localparam int FLD_ALT_CLK_AIS = 0;
  localparam int FLD_FBIT_INS = 0;
  localparam int FLD_MF_INS = 1;
  localparam int FLD_FMT_LO = 2;
  localparam int FLD_MANUAL_AIS = 0;
  localparam int FLD_ON_SIGNAL_LOSS = 1;
  localparam int EVT_MULTIFRAME = 0;
  localparam int EVT_CLK_LOST = 1;
  localparam int EVT_CLK_BACK = 2;
  localparam int EVT_COUNT = 3;
  // ----------------------------------------------------------------
  // Reset values and formats
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [2:0] FMT_SF = 3'h0;
  localparam logic [2:0] FMT_ESF = 3'h1;
  localparam logic [2:0] FMT_SLC = 3'h2;
  localparam logic [2:0] FMT_T1DM = 3'h3;
  localparam logic [2:0] FMT_E1 = 3'h4;
  // ----------------------------------------------------------------
  // Frame geometry and patterns
  // ----------------------------------------------------------------
  localparam int SPARE_BUFS = 5;
  localparam logic [7:0] E1_LAST_BIT = 8'hFF;
  localparam logic [7:0] T1_LAST_BIT = 8'hC0;
  localparam logic [4:0] E1_LAST_FRM = 5'h0F;
  localparam logic [4:0] ESF_LAST_FRM = 5'h17;
  localparam logic [4:0] SF_LAST_FRM = 5'h0B;
  localparam logic [6:0] FAS_WORD = 7'h1B;
  localparam logic [5:0] MFAS_WORD = 6'h0B;
  localparam logic [5:0] FT_WORD = 6'h2A;
  localparam logic [5:0] FS_WORD = 6'h0E;
  localparam logic [5:0] FPS_WORD = 6'h0B;
  localparam int LOSS_EDGES = 8;
  typedef enum logic [1:0] {
    TOI_SEND_DATA = 2'b00,
    TOI_AIS_LINE = 2'b01,
    TOI_AIS_ALT = 2'b11
  } toi_ais_t;
endpackage : toi_pkg

/* design/toi_edge_if.sv */
// Purpose: Carries a synchronised level and its rising edge.
// Assumes: Both ends run on the system clock.
// Notes: Produced by the edge synchroniser.
`timescale 1ns/100ps
interface toi_edge_if;
  logic lvl;
  logic rise;
  modport src (output lvl, output rise);
  modport dst (input lvl, input rise);
endinterface : toi_edge_if

/* design/toi_edge_sync.sv */
// Purpose: Two-stage synchroniser with rising-edge detection.
// Assumes: async_in is from outside the system clock domain.
// Notes: The first stage feeds only the second.
`timescale 1ns/100ps
module toi_edge_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic async_in,
  toi_edge_if.src edge_o
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign edge_o.lvl = sync_reg;
  assign edge_o.rise = sync_reg & ~last_reg;
endmodule : toi_edge_sync

/* design/toi_clk_loss.sv */
// Purpose: Flags loss of the transmit clock against an alternate clock.
// Assumes: Edge pulses are already synchronised to the system clock.
// Notes: Any rising transmit edge clears the count and the flag at once.
`timescale 1ns/100ps
module toi_clk_loss #(
  parameter int LIMIT = toi_pkg::LOSS_EDGES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic alt_rise,
  input wire logic tx_rise,
  output logic lost
);
  logic [3:0] cnt_reg;

  always_ff @(posedge clk) begin
    if (rst || !enable || tx_rise) begin
      cnt_reg <= 4'h0;
    end else if (alt_rise && cnt_reg != 4'(LIMIT)) begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !enable || tx_rise) begin
      lost <= 1'b0;
    end else if (alt_rise && cnt_reg == 4'(LIMIT - 1)) begin
      lost <= 1'b1;
    end
  end
endmodule : toi_clk_loss

/* tb/toi_checker.sv */
// Purpose: Port checks for the overhead insertion block.
// Assumes: Config bits are mirrored from register writes.
// Notes: Windows allow for the two-stage pin synchronisers.
`timescale 1ns/100ps
module toi_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic tx_clock_input,
  input wire logic rx_loss_of_signal_flag,
  input wire logic line_data_out,
  input wire logic line_clock_out,
  input wire logic tx_loss_of_clock_flag,
  input wire logic line_loopback_enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ------------------------------------------------------------
  // Mirrors and idle counters
  // ------------------------------------------------------------
  logic [7:0] alm_reg;
  logic [7:0] liu_reg;
  logic [7:0] loop_reg;
  logic [7:0] tx_idle_reg;
  logic [7:0] lco_idle_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      alm_reg <= 8'h00;
      liu_reg <= 8'h00;
      loop_reg <= 8'h00;
    end else if (wr) begin
      if (addr == toi_pkg::OFS_TX_ALARM) alm_reg <= wdata;
      if (addr == toi_pkg::OFS_TX_LINE_IF) liu_reg <= wdata;
      if (addr == toi_pkg::OFS_LINE_TEST_PATH) loop_reg <= wdata;
    end
  end
  // Counters saturate so a long stop never wraps into a false short gap.
  always_ff @(posedge clk) begin
    if (rst || tx_clock_input != $past(tx_clock_input)) tx_idle_reg <= 8'h00;
    else if (tx_idle_reg != 8'hFF) tx_idle_reg <= tx_idle_reg + 8'h01;
  end
  always_ff @(posedge clk) begin
    if (rst || line_clock_out != $past(line_clock_out)) lco_idle_reg <= 8'h00;
    else if (lco_idle_reg != 8'hFF) lco_idle_reg <= lco_idle_reg + 8'h01;
  end
  manual_ais_a: assert property (alm_reg[0] [*3] |-> line_data_out)
    else $error("manual alarm output not all ones");
  on_signal_loss_a_a: assert property ((alm_reg[1] && rx_loss_of_signal_flag) [*6] |-> line_data_out)
    else $error("signal loss alarm missing");
  keep_alive_a: assert property ((loop_reg[0] && alm_reg[1] && rx_loss_of_signal_flag) [*6]
    |-> line_data_out && line_loopback_enable)
    else $error("loopback keep-alive missing");
  loss_sel_a: assert property ($rose(tx_loss_of_clock_flag) |-> $past(liu_reg[0]))
    else $error("clock loss flagged without alternate select");
  loss_wait_a: assert property ($rose(tx_loss_of_clock_flag) |-> tx_idle_reg >= 8'h30)
    else $error("clock loss flagged too early");
  loss_ais_a: assert property (tx_loss_of_clock_flag [*3] |-> line_data_out)
    else $error("clock loss without alarm output");
  loss_clear_a: assert property ($rose(tx_clock_input) |-> ##[1:6] !tx_loss_of_clock_flag)
    else $error("clock loss flag not cleared");
  alt_clock_a: assert property (alm_reg[0] && liu_reg[0] && tx_idle_reg >= 8'h28
    |-> lco_idle_reg < 8'h0C)
    else $error("line clock not following alternate clock");
endmodule : toi_checker

/* tb/toi_line_model.sv */
// Purpose: Line-side model: transmit and alternate clocks, bit capture.
// Assumes: Line clock and data come from the block under test.
// Notes: The transmit clock stops low when tx_run drops.
`timescale 1ns/100ps
module toi_line_model (
  input wire logic rst,
  input wire logic tx_run,
  input wire logic line_data_out,
  input wire logic line_clock_out,
  output logic tx_clock_input,
  output logic e1_alternate_clock_input,
  output logic t1_alternate_clock_input,
  output logic [4095:0] bits,
  output int bit_count
);
  // ------------------------------------------------------------
  // Clocks and capture
  // ------------------------------------------------------------
  initial begin
    tx_clock_input = 1'b0;
    bit_count = 0;
    bits = '0;
    #3.1;
    forever begin
      #160;
      if (tx_run || tx_clock_input) tx_clock_input = ~tx_clock_input;
    end
  end
  // Alternate clocks run free at line rate, a fixed 4.2 ns behind the transmit clock.
  initial begin
    e1_alternate_clock_input = 1'b0;
    t1_alternate_clock_input = 1'b0;
    #7.3;
    forever begin
      #160;
      e1_alternate_clock_input = ~e1_alternate_clock_input;
      t1_alternate_clock_input = ~t1_alternate_clock_input;
    end
  end
  // Sampled mid-bit on the falling edge, away from the launching edge.
  always @(negedge line_clock_out) begin
    if (!rst) begin
      bits[bit_count % 4096] <= line_data_out;
      bit_count <= bit_count + 1;
    end
  end
endmodule : toi_line_model

/* tb/testbench.sv */
// Purpose: Self-checking bench for the overhead insertion block.
// Assumes: E1 format for the spare-bit run; transmit data held at zero.
// Notes: One multiframe is 4096 line bits, about 33k system clocks.
`timescale 1ns/100ps
module testbench;
  // ------------------------------------------------------------
  // Stimulus and checks
  // ------------------------------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic tx_data_in = 1'b0;
  logic loss_in = 1'b0;
  logic tx_run = 1'b0;
  logic [7:0] rdata;
  logic tx_clk, e1_clk, t1_clk, line_data, line_clk, loc_flag, loopback, irq;
  logic [4095:0] bits;
  int bit_count;
  int errors = 0;
  int check_count = 0;
  logic [7:0] bufv [5] = '{8'hA5, 8'hFF, 8'h00, 8'hFF, 8'h5A};
  always #20 clk = ~clk;
  toi_tx_overhead dut_u (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .tx_clock_input(tx_clk), .e1_alternate_clock_input(e1_clk),
    .t1_alternate_clock_input(t1_clk), .tx_data_in(tx_data_in),
    .rx_loss_of_signal_flag(loss_in), .line_data_out(line_data), .line_clock_out(line_clk),
    .tx_loss_of_clock_flag(loc_flag), .line_loopback_enable(loopback), .irq(irq));
  toi_line_model model_u (.rst(rst), .tx_run(tx_run), .line_data_out(line_data),
    .line_clock_out(line_clk), .tx_clock_input(tx_clk), .e1_alternate_clock_input(e1_clk),
    .t1_alternate_clock_input(t1_clk), .bits(bits), .bit_count(bit_count));
  task automatic end_sim();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check8
  task automatic timed_out(input int i, input int lim);
    if (i >= lim) begin
      errors++;
      end_sim();
    end
  endtask : timed_out
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
    @(posedge clk);
  endtask : rd_reg
  task automatic reg_scen();
    logic [7:0] d;
    rd_reg(toi_pkg::OFS_TX_FRAME_FMT, d);
    check8(d, toi_pkg::RST_CONFIG);
    wr_reg(toi_pkg::OFS_TX_MAN_SPARE, 8'h11);
    rd_reg(toi_pkg::OFS_TX_MAN_SPARE, d);
    check8(d, 8'h11);
    rd_reg(8'hA0, d);
    check8(d, 8'h00);
  endtask : reg_scen
  task automatic spare_scen();
    logic [7:0] d;
    logic [7:0] exp;
    int i;
    int j;
    int n;
    wr_reg(toi_pkg::OFS_TX_FRAME_FMT, 8'h13);
    for (i = 0; i < 5; i++) wr_reg(toi_pkg::OFS_SPARE_FIRST + 8'(i), bufv[i]);
    wr_reg(toi_pkg::OFS_IRQ_ENABLE, 8'h01);
    tx_run <= 1'b1;
    for (i = 0; i < 40000 && irq !== 1'b1; i++) @(negedge clk);
    timed_out(i, 40000);
    @(posedge clk);
    // Rewritten at once: must not reach the multiframe already sampled.
    wr_reg(toi_pkg::OFS_SPARE_FIRST, 8'h00);
    rd_reg(toi_pkg::OFS_IRQ_STATUS, d);
    check8(d & 8'h01, 8'h01);
    wr_reg(toi_pkg::OFS_IRQ_ENABLE, 8'h00);
    rd_reg(toi_pkg::OFS_IRQ_STATUS, d);
    check8({7'h00, irq}, 8'h00);
    wr_reg(toi_pkg::OFS_IRQ_CLEAR, 8'h01);
    wr_reg(toi_pkg::OFS_IRQ_ENABLE, 8'h01);
    rd_reg(toi_pkg::OFS_IRQ_STATUS, d);
    check8({6'h00, d[0], irq}, 8'h00);
    for (i = 0; i < 40000 && bit_count < 8100; i++) @(negedge clk);
    timed_out(i, 40000);
    @(posedge clk);
    for (i = 0; i < 16; i++) begin
      for (j = 0; j < 8; j++) d[7 - j] = bits[i * 256 + j];
      n = i / 2;
      exp = {1'b0, toi_pkg::FAS_WORD};
      if (i % 2 == 1) begin
        exp = {(n < 6) ? toi_pkg::MFAS_WORD[5 - n] : 1'b0, 7'h40};
        exp[4] = bufv[0][n];
        exp[0] = bufv[4][n];
      end
      check8(d, exp);
    end
  endtask : spare_scen
  task automatic ais_scen();
    logic [7:0] d;
    int i;
    wr_reg(toi_pkg::OFS_TX_LINE_IF, 8'h01);
    wr_reg(toi_pkg::OFS_TX_ALARM, 8'h01);
    repeat (3) @(posedge clk);
    check8({7'h00, line_data}, 8'h01);
    tx_run <= 1'b0;
    for (i = 0; i < 200 && loc_flag !== 1'b1; i++) @(negedge clk);
    timed_out(i, 200);
    @(posedge clk);
    wr_reg(toi_pkg::OFS_TX_ALARM, 8'h00);
    repeat (4) @(posedge clk);
    check8({6'h00, loc_flag, line_data}, 8'h03);
    rd_reg(toi_pkg::OFS_IRQ_STATUS, d);
    check8(d & 8'h02, 8'h02);
    tx_run <= 1'b1;
    for (i = 0; i < 100 && loc_flag !== 1'b0; i++) @(negedge clk);
    timed_out(i, 100);
    @(posedge clk);
    check8({7'h00, loc_flag}, 8'h00);
    wr_reg(toi_pkg::OFS_LINE_TEST_PATH, 8'h01);
    wr_reg(toi_pkg::OFS_TX_ALARM, 8'h02);
    loss_in <= 1'b1;
    repeat (8) @(posedge clk);
    check8({6'h00, loopback, line_data}, 8'h03);
    loss_in <= 1'b0;
  endtask : ais_scen
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    reg_scen();
    spare_scen();
    ais_scen();
    end_sim();
  end
endmodule : testbench
bind toi_tx_overhead toi_checker chk_u (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
  .wr(wr), .tx_clock_input(tx_clock_input), .rx_loss_of_signal_flag(rx_loss_of_signal_flag),
  .line_data_out(line_data_out), .line_clock_out(line_clock_out),
  .tx_loss_of_clock_flag(tx_loss_of_clock_flag), .line_loopback_enable(line_loopback_enable));
